// ### logic/gspd_pkg.sv
// package for the global sector protect decoder: opcodes, status layout, reset values
// assumes a single 10 MHz reference clock that samples every serial pin
package gspd_pkg;
	// ==========================================================
	// command opcodes
	localparam logic [7:0] GSPD_OP_WREN     = 8'h06;
	localparam logic [7:0] GSPD_OP_WRDI     = 8'h04;
	localparam logic [7:0] GSPD_OP_WRSR1    = 8'h01;
	localparam logic [7:0] GSPD_OP_RDSR     = 8'h05;
	localparam logic [7:0] GSPD_OP_PROT     = 8'h36;
	localparam logic [7:0] GSPD_OP_UNPROT   = 8'h39;

	// ==========================================================
	// protection status byte fields
	localparam int GSPD_BIT_LOCK     = 7;
	localparam int GSPD_BIT_WPPIN    = 4;
	localparam int GSPD_BIT_WEL      = 1;
	localparam int GSPD_DEC_HI       = 5;
	localparam int GSPD_DEC_LO       = 2;
	localparam logic [3:0] GSPD_DEC_ALL  = 4'hF;
	localparam logic [3:0] GSPD_DEC_NONE = 4'h0;
	localparam logic [1:0] GSPD_SWP_NONE = 2'h0;
	localparam logic [1:0] GSPD_SWP_SOME = 2'h1;
	localparam logic [1:0] GSPD_SWP_ALL  = 2'h3;

	// ==========================================================
	// sizes, counts and reset values
	localparam int GSPD_NSECT          = 16;
	localparam logic [2:0] GSPD_BIT_LAST   = 3'h7;
	localparam logic [2:0] GSPD_BYTE_DATA  = 3'h1;
	localparam logic [2:0] GSPD_BYTE_ADDR  = 3'h4;
	localparam logic [2:0] GSPD_BYTE_SAT   = 3'h7;
	localparam logic [15:0] GSPD_SECT_RST  = 16'hFFFF;
	localparam logic GSPD_LOCK_RST         = 1'b0;
	localparam logic GSPD_WEL_RST          = 1'b0;
	localparam int GSPD_SYNC_W         = 4;

	// serial pins as sampled together
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic wp_n;
	} gspd_pins_type;
endpackage

// ### logic/gspd_sync.sv
// two-stage level synchroniser for a bundle of pins
// assumes inputs are asynchronous to clk and quasi-static per bit
`timescale 1ns/100ps
module gspd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_r <= rst_val;
			q      <= rst_val;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ### logic/gspd_top.sv
// serial flash status byte one decoder: global protect/unprotect, lock bit, sector bits
// assumes SPI mode 0 host, serial clock well below a quarter of REF_CLK
// Functional notes
// - locking permits, bits 5..2 all ones: set every sector bit
// - locking permits, bits 5..2 all zeros: clear every sector bit
// - mixed bits 5..2 leave sectors alone; bits 6,1,0 ignored
// - lock bit clear: write loads byte bit 7 into lock bit
// - pin low and lock set: status write leaves lock and sectors alone, only clears the enable latch
// - pin high and lock set: no global op, lock may clear
// - bits 5..2 never stored; read back shows pin and sector summary
// - 0Fh clears lock (pin high) without global op; F0h sets lock only
// - per-sector protect and unprotect still work after a global op
// - write enable latch must be set before a status write executes
// - sector bit zero allows program and erase, one blocks both
// - hardware lock only when pin asserted and lock bit set
`timescale 1ns/100ps
module gspd_top
	import gspd_pkg::*;
(
	input  wire logic                   REF_CLK,
	input  wire logic                   SRST,
	input  wire logic                   CS_N,
	input  wire logic                   SCK,
	input  wire logic                   SI,
	input  wire logic                   WP_N,
	output logic                        SO_O,
	output logic                        SO_OE,
	output logic      [GSPD_NSECT-1:0]  SECTOR_WRITABLE,
	output logic                        HW_LOCKED
);
	// ==========================================================
	// pin synchronisation
	gspd_pins_type pins_raw;
	gspd_pins_type pins_s;
	gspd_pins_type pins_rst;
	logic          sck_d_r;
	logic          cs_d_r;

	assign pins_raw = '{cs_n: CS_N, sck: SCK, si: SI, wp_n: WP_N};
	assign pins_rst = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};

	gspd_sync #(.W(GSPD_SYNC_W)) u_sync (
		.clk     (REF_CLK),
		.srst    (SRST),
		.d       (pins_raw),
		.rst_val (pins_rst),
		.q       (pins_s)
	);

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			sck_d_r <= 1'b0;
			cs_d_r  <= 1'b1;
		end else begin
			sck_d_r <= pins_s.sck;
			cs_d_r  <= pins_s.cs_n;
		end
	end

	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	assign sck_rise = pins_s.sck & ~sck_d_r & ~pins_s.cs_n;
	assign sck_fall = ~pins_s.sck & sck_d_r & ~pins_s.cs_n;
	assign cs_rise  = pins_s.cs_n & ~cs_d_r;

	// ==========================================================
	// byte assembly
	logic [7:0] shift_r;
	logic [2:0] bit_cnt_r;
	logic [2:0] byte_cnt_r;
	logic [7:0] opcode_r;
	logic [7:0] data_r;
	logic [3:0] sect_idx_r;
	logic [7:0] byte_nxt;
	logic       byte_done;

	assign byte_nxt  = {shift_r[6:0], pins_s.si};
	assign byte_done = sck_rise & (bit_cnt_r == GSPD_BIT_LAST);

	always_ff @(posedge REF_CLK) begin
		if (SRST | pins_s.cs_n) begin
			shift_r    <= 8'h00;
			bit_cnt_r  <= 3'h0;
			byte_cnt_r <= 3'h0;
		end else if (sck_rise) begin
			shift_r   <= byte_nxt;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (byte_done && byte_cnt_r != GSPD_BYTE_SAT)
				byte_cnt_r <= byte_cnt_r + 3'h1;
		end
	end

	// opcode, first data byte, and sector number from the top address byte
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			opcode_r   <= 8'h00;
			data_r     <= 8'h00;
			sect_idx_r <= 4'h0;
		end else if (byte_done) begin
			if (byte_cnt_r == 3'h0)
				opcode_r <= byte_nxt;
			if (byte_cnt_r == GSPD_BYTE_DATA) begin
				data_r     <= byte_nxt;
				sect_idx_r <= byte_nxt[3:0];
			end
		end
	end

	// ==========================================================
	// command execution at deselect
	logic                  lock_r;
	logic                  wel_r;
	logic [GSPD_NSECT-1:0] sect_r;
	logic                  on_boundary;
	logic                  exec;
	logic                  is_wrsr;
	logic                  is_sect_cmd;
	logic                  hw_lock;
	logic [3:0]            dec;

	assign on_boundary = (bit_cnt_r == 3'h0);
	assign exec        = cs_rise & on_boundary;
	assign is_wrsr     = (opcode_r == GSPD_OP_WRSR1) && (byte_cnt_r >= 3'h2);
	assign is_sect_cmd = (opcode_r == GSPD_OP_PROT) || (opcode_r == GSPD_OP_UNPROT);
	assign hw_lock     = ~pins_s.wp_n & lock_r;
	assign dec         = data_r[GSPD_DEC_HI:GSPD_DEC_LO];

	// bits 5..2 are only decoded here, never kept
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			lock_r <= GSPD_LOCK_RST;
			sect_r <= GSPD_SECT_RST;
		end else if (exec && wel_r && is_wrsr && !hw_lock) begin
			lock_r <= data_r[GSPD_BIT_LOCK];
			if (!lock_r) begin
				if (dec == GSPD_DEC_ALL)
					sect_r <= GSPD_SECT_RST;
				else if (dec == GSPD_DEC_NONE)
					sect_r <= '0;
			end // mixed patterns fall through untouched
		end else if (exec && wel_r && is_sect_cmd && byte_cnt_r >= GSPD_BYTE_ADDR && !lock_r) begin
			sect_r[sect_idx_r] <= (opcode_r == GSPD_OP_PROT);
		end
	end

	// latch is consumed by any status write or sector command, even an aborted one
	always_ff @(posedge REF_CLK) begin
		if (SRST)
			wel_r <= GSPD_WEL_RST;
		else if (cs_rise) begin
			if (opcode_r == GSPD_OP_WREN && on_boundary && byte_cnt_r != 3'h0)
				wel_r <= 1'b1;
			else if (opcode_r == GSPD_OP_WRDI && on_boundary && byte_cnt_r != 3'h0)
				wel_r <= 1'b0;
			else if ((opcode_r == GSPD_OP_WRSR1 || is_sect_cmd) && byte_cnt_r != 3'h0)
				wel_r <= 1'b0;
		end
	end

	// ==========================================================
	// status read back: written bits 5..2 replaced by live state
	logic [1:0] swp;
	logic [7:0] status;
	logic [7:0] so_sh_r;
	logic       rd_r;

	always_comb begin
		if (&sect_r)
			swp = GSPD_SWP_ALL;
		else if (sect_r == '0)
			swp = GSPD_SWP_NONE;
		else
			swp = GSPD_SWP_SOME;
	end

	assign status = {lock_r, 2'b00, pins_s.wp_n, swp, wel_r, 1'b0};

	// reload each byte so repeated reads follow live state
	always_ff @(posedge REF_CLK) begin
		if (SRST | pins_s.cs_n) begin
			rd_r    <= 1'b0;
			so_sh_r <= 8'h00;
			SO_O    <= 1'b0;
		end else if (byte_done && (rd_r || (byte_cnt_r == 3'h0 && byte_nxt == GSPD_OP_RDSR))) begin
			rd_r    <= 1'b1;
			so_sh_r <= status;
		end else if (sck_fall && rd_r) begin
			SO_O    <= so_sh_r[7];
			so_sh_r <= {so_sh_r[6:0], 1'b0};
		end
	end

	assign SO_OE           = rd_r & ~pins_s.cs_n;
	assign SECTOR_WRITABLE = ~sect_r;
	assign HW_LOCKED       = hw_lock;

	// ==========================================================
	// checks
	AST_GLOBAL_PROT: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && wel_r && is_wrsr && !lock_r && dec == GSPD_DEC_ALL |=> &sect_r)
		else $error("global protect did not set all sectors");

	AST_GLOBAL_UNPROT: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && wel_r && is_wrsr && !lock_r && dec == GSPD_DEC_NONE |=> sect_r == '0)
		else $error("global unprotect did not clear all sectors");

	AST_MIXED_KEEP: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && is_wrsr && dec != GSPD_DEC_ALL && dec != GSPD_DEC_NONE |=> $stable(sect_r))
		else $error("mixed pattern changed sector bits");

	AST_LOCK_LOAD: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && wel_r && is_wrsr && !lock_r |=> lock_r == $past(data_r[GSPD_BIT_LOCK]))
		else $error("lock bit not loaded from bit seven");

	AST_HW_LOCK: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && is_wrsr && !pins_s.wp_n && lock_r |=> lock_r && $stable(sect_r))
		else $error("hardware locked write had an effect");

	AST_SOFT_LOCK: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && is_wrsr && pins_s.wp_n && lock_r |=> $stable(sect_r))
		else $error("soft locked write performed a global operation");

	AST_WEL_GATE: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && is_wrsr && !wel_r |=> $stable(lock_r) && $stable(sect_r))
		else $error("status write ran without write enable");

	AST_DESELECT_ONLY: assert property (@(posedge REF_CLK) disable iff (SRST)
		!exec |=> $stable(lock_r) && $stable(sect_r))
		else $error("protection state changed outside deselect");

	AST_SECTOR_OP: assert property (@(posedge REF_CLK) disable iff (SRST)
		exec && wel_r && !lock_r && opcode_r == GSPD_OP_UNPROT && byte_cnt_r >= GSPD_BYTE_ADDR
		|=> !sect_r[$past(sect_idx_r)])
		else $error("sector unprotect failed");
endmodule

// ### tb/gspd_host.sv
// behavioural spi mode 0 host that frames whole transfers on the serial pins
// assumes clk is the 10 MHz reference; sck half period is four clk cycles
`timescale 1ns/100ps
module gspd_host (
	input  wire logic clk,
	input  wire logic so,
	output logic      cs_n,
	output logic      sck,
	output logic      si
);
	initial begin
		cs_n = 1'h1;
		sck = 1'h0;
		si = 1'h0;
	end

	task automatic half();
		repeat (4) @(posedge clk);
		#1;
	endtask

	// ==========================================================
	// one frame: n bits of w msb first; r keeps the last eight bits seen
	task automatic send(input logic [31:0] w, input int n, output logic [7:0] r);
		cs_n = 1'h0;
		r = 8'h00;
		for (int i = 0; i < n; i++) begin
			si = w[31-i];
			half();
			sck = 1'h1;
			r = {r[6:0], so};
			half();
			sck = 1'h0;
		end
		half();
		cs_n = 1'h1;
		// released data line must not keep showing the last bit
		si = ~si;
		repeat (6) @(posedge clk);
		#1;
	endtask
endmodule

// ### tb/gspd_top_test.sv
// self-checking bench for the status byte one decoder against an integer model
// assumes the host model drives the serial pins and the bench drives the pin WP_N
`timescale 1ns/100ps
module gspd_top_test
	import gspd_pkg::*;
;
	logic        ref_clk;
	logic        srst;
	logic        wp_n;
	wire logic   cs_n;
	wire logic   sck;
	wire logic   si;
	logic        so_o;
	logic        so_oe;
	logic [15:0] sect_wr;
	logic        hw_locked;
	wire logic   so_seen;
	logic [7:0]  rx_byte;
	int          errors;
	int          n_compared;
	int          seed;
	logic        lock;
	logic        write_enable_latch;
	logic [15:0] sect;
	logic [11:0] tbl [13];

	gspd_top u_dut (.REF_CLK(ref_clk), .SRST(srst), .CS_N(cs_n), .SCK(sck), .SI(si),
		.WP_N(wp_n), .SO_O(so_o), .SO_OE(so_oe), .SECTOR_WRITABLE(sect_wr),
		.HW_LOCKED(hw_locked));
	// undriven output shows the inverse, so a missing enable spoils the read back
	assign so_seen = so_oe ? so_o : ~so_o;
	gspd_host u_host (.clk(ref_clk), .so(so_seen), .cs_n(cs_n), .sck(sck), .si(si));

	initial ref_clk = 1'h0;
	always #50 ref_clk = ~ref_clk;

	// ==========================================================
	// compare and close
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	function automatic logic [7:0] stat_exp();
		logic [1:0] swp;
		swp = (sect == 16'h0000) ? GSPD_SWP_NONE : (sect == 16'hFFFF) ? GSPD_SWP_ALL : GSPD_SWP_SOME;
		return {lock, 2'h0, wp_n, swp, write_enable_latch, 1'h0};
	endfunction

	// ==========================================================
	// e: [11:10] kind (0 status, 1 unprotect, 2 protect, 3 cut), [9] pin, [8] enable, data
	task automatic do_op(input logic [11:0] e);
		logic [7:0] r;
		logic [7:0] d;
		d = e[7:0];
		wp_n = e[9];
		if (e[8]) begin
			u_host.send({GSPD_OP_WREN, 24'h00_0000}, 8, r);
			write_enable_latch = 1'h1;
		end
		case (e[11:10])
			2'h0: begin
				u_host.send({GSPD_OP_WRSR1, d, 16'h0000}, 16, r);
				if (write_enable_latch && !(!wp_n && lock)) begin
					if (!lock && d[5:2] == GSPD_DEC_ALL) sect = 16'hFFFF;
					if (!lock && d[5:2] == GSPD_DEC_NONE) sect = 16'h0000;
					lock = d[7];
				end
			end
			2'h3: begin
				// cut mid byte: nothing may change but the enable latch
				u_host.send({GSPD_OP_WRSR1, d, 16'h0000}, 12, r);
			end
			default: begin
				u_host.send({e[10] ? GSPD_OP_UNPROT : GSPD_OP_PROT, 4'h0, d[3:0],
					16'h0000}, 32, r);
				if (write_enable_latch && !lock) sect[d[3:0]] = !e[10];
			end
		endcase
		write_enable_latch = 1'h0;
		u_host.send({GSPD_OP_RDSR, 24'h00_0000}, 16, r);
		chk(sect_wr, ~sect);
		chk({15'h0000, hw_locked}, {15'h0000, !wp_n && lock});
		chk({8'h00, r}, {8'h00, stat_exp()});
		chk({15'h0000, so_oe}, 16'h0000);
	endtask

	initial begin
		#8_000_000;
		errors++;
		end_of_test();
	end

	initial begin
		errors = 0;
		n_compared = 0;
		seed = 90984;
		srst = 1'h1;
		wp_n = 1'h1;
		lock = GSPD_LOCK_RST;
		write_enable_latch = GSPD_WEL_RST;
		sect = GSPD_SECT_RST;
		tbl = '{12'h200, 12'h37F, 12'h300, 12'h3F0, 12'h300, 12'h3FF, 12'h100,
			12'h30F, 12'h184, 12'h30F, 12'h703, 12'hB03, 12'hF00};
		repeat (12) @(posedge ref_clk);
		#1;
		srst = 1'h0;
		foreach (tbl[i]) do_op(tbl[i]);
		// latch must read back set, then a disable must make the next status write refused
		u_host.send({GSPD_OP_WREN, 24'h00_0000}, 8, rx_byte);
		write_enable_latch = 1'h1;
		u_host.send({GSPD_OP_RDSR, 24'h00_0000}, 16, rx_byte);
		chk({8'h00, rx_byte}, {8'h00, stat_exp()});
		u_host.send({GSPD_OP_WRDI, 24'h00_0000}, 8, rx_byte);
		write_enable_latch = 1'h0;
		do_op(12'h200);
		for (int i = 0; i < 40; i++) begin
			do_op(12'($random(seed)));
		end
		end_of_test();
	end
endmodule
